// ---- verilog/port_pin_function_control.sv ----
// pin function, direction, drive and level-change interrupt control
// How it works
// R1 - enabled input-mode pin raises external irq zero on a level change seen at a sampling tick
// R2 - disabled pin never raises the irq; reset clears all enables
// R3 - pin33_control at 17H: enable b3, serial input b2, dir b1, drive b0
// R4 - serial input select forces pin 3.3 to input mode
// R5 - pin41_control at 19H: enable b3, data ready b2, dir b1, drive b0
// R6 - data ready select drives ready signal, forces pin 4.1 to output
// R7 - pin42_control: enable b3, serial clock b2, dir b1, drive b0
// R8 - serial clock select; direction follows external clock choice bit
// R9 - pin43_control at 1BH: enable b3, osc watch b2, dir b1, drive b0
// R10 - osc watch select outputs rc clock, forces pin 4.3 to output
// R11 - function select zero means plain port; that is the reset value
// R12 - direction zero is input, one is output; input after reset
// R13 - input mode: drive bit zero biased by resistor, one floating
// R14 - output mode: drive bit zero push-pull, one open drain
// R15 - software writes whole values only; pin control registers read back as zero
// R16 - irq request is the OR of all enabled pin change detections
// R17 - change detection always samples at the 64 Hz tick
// R18 - irq set within one sampling period of an enabled change
// R19 - shared pull polarity: zero pull-up, one pull-down
// R20 - pad enable follows dir unless function select forces it
`timescale 1ns/10ps
`include "port_pin_defs.svh"
`default_nettype none

module port_pin_function_control
#(
  parameter int SAMPLE_DIV = `PPF_SAMPLE_DIV
)
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // pads
  input wire logic [3:0] i_pad_in,
  output logic [3:0] o_pad_out,
  output logic [3:0] o_pad_oe,
  output logic [3:0] o_pull_up_en,
  output logic [3:0] o_pull_down_en,
  // port data path
  input wire logic [3:0] i_port_data,
  output logic [3:0] o_port_level,
  // serial port and oscillator monitor
  input wire logic i_external_clock_choice,
  input wire logic i_serial_data_ready,
  input wire logic i_serial_clock_out,
  input wire logic i_rc_osc_clk,
  output logic o_serial_data_in,
  output logic o_serial_clock_in,
  // interrupt request
  output logic o_external_irq_zero
);
  import port_pin_pkg::*;

  // ==========================================================
  // bus slave
  // ==========================================================
  localparam logic [18:0] TICK_LAST = 19'(SAMPLE_DIV - 1);

  pin_ctrl_s ctrl_r [4];
  logic pull_polarity_r;
  logic wr_pend_r;
  reg_index_t wr_idx_r;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;

  wire logic addr_take = i_hsel & i_htrans[1] & i_hready;
  wire reg_index_t addr_idx = i_haddr[9:2];
  wire logic [3:0] slot_hit;
  assign slot_hit[`PPF_SLOT_P33] = (wr_idx_r == `PPF_IDX_PIN33_CTRL);
  assign slot_hit[`PPF_SLOT_P41] = (wr_idx_r == `PPF_IDX_PIN41_CTRL);
  assign slot_hit[`PPF_SLOT_P42] = (wr_idx_r == `PPF_IDX_PIN42_CTRL);
  assign slot_hit[`PPF_SLOT_P43] = (wr_idx_r == `PPF_IDX_PIN43_CTRL);
  wire logic pol_hit = wr_pend_r & (wr_idx_r == `PPF_IDX_PULL_POL);

  logic [3:0] level_s;
  logic [3:0] sample_r;
  logic [3:0] irq_arm;

  // control registers are write-only and read back as zero [R15]
  always_comb
  begin
    hrdata_nxt = 32'h0000_0000;
    if (addr_idx == `PPF_IDX_PULL_POL)
      hrdata_nxt = {31'h0000_0000, pull_polarity_r};
    else if (addr_idx == `PPF_IDX_STATUS)
      hrdata_nxt = {24'h00_0000, irq_arm, level_s};
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= addr_take & i_hwrite;
      if (addr_take)
        wr_idx_r <= addr_idx;
      if (addr_take & ~i_hwrite)
        hrdata_r <= hrdata_nxt;
    end
  end

  // reset leaves every pin a plain input with no irq [R2] [R11] [R12]
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ctrl
      always_ff @(posedge i_clk_sys or negedge i_rstn)
      begin
        if (!i_rstn)
          ctrl_r[g] <= `PPF_CTRL_RST;
        else if (wr_pend_r & slot_hit[g])
          ctrl_r[g] <= i_hwdata[3:0]; // [R3] [R5] [R7] [R9]
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      pull_polarity_r <= `PPF_PULL_POL_RST;
    else if (pol_hit)
      pull_polarity_r <= i_hwdata[0];
  end

  assign o_hrdata = hrdata_r;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // ==========================================================
  // pad input synchronisers
  // ==========================================================
  logic [3:0] pad_meta_r;
  logic [3:0] pad_sync_r;
  logic osc_meta_r;
  logic osc_sync_r;

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pad_meta_r <= 4'h0;
      pad_sync_r <= 4'h0;
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
    end
    else
    begin
      pad_meta_r <= i_pad_in;
      pad_sync_r <= pad_meta_r;
      osc_meta_r <= i_rc_osc_clk;
      osc_sync_r <= osc_meta_r;
    end
  end
  assign level_s = pad_sync_r;

  // ==========================================================
  // pad direction, drive and bias
  // ==========================================================
  logic [3:0] forced_dir;
  logic [3:0] func_data;
  logic [3:0] dir_eff;
  logic [3:0] data_eff;
  pad_drive_s pad_nxt [4];

  // function overrides of direction and data
  assign forced_dir[`PPF_SLOT_P33] = 1'b0; // [R4]
  assign forced_dir[`PPF_SLOT_P41] = 1'b1; // [R6]
  assign forced_dir[`PPF_SLOT_P42] = ~i_external_clock_choice; // [R8]
  assign forced_dir[`PPF_SLOT_P43] = 1'b1; // [R10]
  assign func_data[`PPF_SLOT_P33] = i_port_data[`PPF_SLOT_P33];
  assign func_data[`PPF_SLOT_P41] = i_serial_data_ready; // [R6]
  assign func_data[`PPF_SLOT_P42] = i_serial_clock_out; // [R8]
  assign func_data[`PPF_SLOT_P43] = osc_sync_r; // [R10]

  generate
    for (g = 0; g < 4; g++)
    begin : g_pad
      // the selected function wins over the direction bit [R20]
      assign dir_eff[g] = ctrl_r[g].func_sel ? forced_dir[g]
                                             : ctrl_r[g].dir; // [R12]
      assign data_eff[g] = ctrl_r[g].func_sel ? func_data[g]
                                              : i_port_data[g]; // [R11]
      // open drain only sinks: enable follows a low data bit [R14]
      assign pad_nxt[g].out = ctrl_r[g].drive_mode ? 1'b0 : data_eff[g];
      assign pad_nxt[g].oe = dir_eff[g]
                             & (~ctrl_r[g].drive_mode | ~data_eff[g]);
      // resistor bias only in input mode with drive bit zero [R13] [R19]
      assign pad_nxt[g].pull_up = ~dir_eff[g] & ~ctrl_r[g].drive_mode
                                  & ~pull_polarity_r;
      assign pad_nxt[g].pull_down = ~dir_eff[g] & ~ctrl_r[g].drive_mode
                                    & pull_polarity_r;
      assign irq_arm[g] = ctrl_r[g].irq_en & ~dir_eff[g]; // [R1] [R2]

      always_ff @(posedge i_clk_sys or negedge i_rstn)
      begin
        if (!i_rstn)
        begin
          o_pad_out[g] <= 1'b0;
          o_pad_oe[g] <= 1'b0;
          o_pull_up_en[g] <= 1'b0;
          o_pull_down_en[g] <= 1'b0;
        end
        else
        begin
          o_pad_out[g] <= pad_nxt[g].out;
          o_pad_oe[g] <= pad_nxt[g].oe;
          o_pull_up_en[g] <= pad_nxt[g].pull_up;
          o_pull_down_en[g] <= pad_nxt[g].pull_down;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_port_level <= 4'h0;
      o_serial_data_in <= 1'b0;
      o_serial_clock_in <= 1'b0;
    end
    else
    begin
      o_port_level <= level_s;
      o_serial_data_in <= ctrl_r[`PPF_SLOT_P33].func_sel
                          & level_s[`PPF_SLOT_P33]; // [R4]
      o_serial_clock_in <= ctrl_r[`PPF_SLOT_P42].func_sel
                           & i_external_clock_choice
                           & level_s[`PPF_SLOT_P42]; // [R8]
    end
  end

  // ==========================================================
  // 64 Hz sampling and change detection
  // ==========================================================
  logic [18:0] tick_cnt_r;
  logic tick_r;
  wire logic tick_wrap = (tick_cnt_r == TICK_LAST);
  // a pin level that moves and returns within one tick is missed;
  // that is the price of the fixed low sampling rate
  wire logic [3:0] change_hit = irq_arm & (level_s ^ sample_r);

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tick_cnt_r <= 19'h0_0000;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_cnt_r <= tick_wrap ? 19'h0_0000 : tick_cnt_r + 19'h0_0001;
      tick_r <= tick_wrap; // [R17]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sample_r <= 4'h0;
      o_external_irq_zero <= 1'b0;
    end
    else
    begin
      if (tick_r)
        sample_r <= level_s; // [R17]
      o_external_irq_zero <= tick_r & (|change_hit); // [R16] [R18]
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  a_irq_has_cause: assert property ( // [R1] [R16]
    o_external_irq_zero |-> $past(tick_r) && $past(|change_hit))
    else $error("irq pulse without an armed level change");

  a_irq_none_disabled: assert property ( // [R2]
    $past(irq_arm) == 4'h0 |-> !o_external_irq_zero)
    else $error("irq from a disabled pin");

  a_irq_when_change: assert property ( // [R18]
    tick_r && (|change_hit) |=> o_external_irq_zero)
    else $error("armed change at tick did not raise irq");

  a_pin33_write: assert property ( // [R3]
    wr_pend_r && wr_idx_r == `PPF_IDX_PIN33_CTRL
    |=> ctrl_r[`PPF_SLOT_P33] == $past(i_hwdata[3:0]))
    else $error("pin33 control write lost");

  a_pin41_write: assert property ( // [R5]
    wr_pend_r && wr_idx_r == `PPF_IDX_PIN41_CTRL
    |=> ctrl_r[`PPF_SLOT_P41] == $past(i_hwdata[3:0]))
    else $error("pin41 control write lost");

  a_pin42_write: assert property ( // [R7]
    wr_pend_r && wr_idx_r == `PPF_IDX_PIN42_CTRL
    |=> ctrl_r[`PPF_SLOT_P42] == $past(i_hwdata[3:0]))
    else $error("pin42 control write lost");

  a_pin43_write: assert property ( // [R9]
    wr_pend_r && wr_idx_r == `PPF_IDX_PIN43_CTRL
    |=> ctrl_r[`PPF_SLOT_P43] == $past(i_hwdata[3:0]))
    else $error("pin43 control write lost");

  a_serial_in_input: assert property ( // [R4]
    ctrl_r[`PPF_SLOT_P33].func_sel |=> !o_pad_oe[`PPF_SLOT_P33])
    else $error("serial input pin driven");

  a_ready_drive: assert property ( // [R6]
    ctrl_r[`PPF_SLOT_P41].func_sel && !ctrl_r[`PPF_SLOT_P41].drive_mode
    |=> o_pad_oe[`PPF_SLOT_P41]
        && o_pad_out[`PPF_SLOT_P41] == $past(i_serial_data_ready))
    else $error("data ready not driven on pin 4.1");

  a_sclk_direction: assert property ( // [R8]
    ctrl_r[`PPF_SLOT_P42].func_sel && !ctrl_r[`PPF_SLOT_P42].drive_mode
    |=> o_pad_oe[`PPF_SLOT_P42] == !$past(i_external_clock_choice))
    else $error("serial clock direction wrong");

  a_monitor_drive: assert property ( // [R10]
    ctrl_r[`PPF_SLOT_P43].func_sel && !ctrl_r[`PPF_SLOT_P43].drive_mode
    |=> o_pad_oe[`PPF_SLOT_P43])
    else $error("monitor pin not driven");

  a_pull_choice: assert property ( // [R19] [R13]
    !dir_eff[0] && !ctrl_r[0].drive_mode
    |=> o_pull_up_en[0] == !$past(pull_polarity_r) && o_pull_down_en[0]
        == $past(pull_polarity_r))
    else $error("pull polarity not applied");

  a_tick_spacing: assert property ( // [R17]
    tick_r |-> $past(tick_cnt_r) == TICK_LAST)
    else $error("sampling tick off its period");

  c_irq_seen: cover property (o_external_irq_zero);
  c_sclk_input: cover property (
    ctrl_r[`PPF_SLOT_P42].func_sel && i_external_clock_choice);
  c_open_drain: cover property (
    ctrl_r[`PPF_SLOT_P41].dir && ctrl_r[`PPF_SLOT_P41].drive_mode);

endmodule // port_pin_function_control

`default_nettype wire

// ---- include/port_pin_defs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef PORT_PIN_DEFS_SVH
`define PORT_PIN_DEFS_SVH

// register indices; byte address is four times the index
`define PPF_IDX_PIN33_CTRL 8'h17
`define PPF_IDX_PIN41_CTRL 8'h19
`define PPF_IDX_PIN42_CTRL 8'h1A
`define PPF_IDX_PIN43_CTRL 8'h1B
`define PPF_IDX_PULL_POL 8'h20
`define PPF_IDX_STATUS 8'h21

// control field positions
`define PPF_BIT_IRQ_EN 3
`define PPF_BIT_FUNC_SEL 2
`define PPF_BIT_DIR 1
`define PPF_BIT_DRIVE 0

// reset values
`define PPF_CTRL_RST 4'h0
`define PPF_PULL_POL_RST 1'b0

// pin slots in the vectors
`define PPF_SLOT_P33 0
`define PPF_SLOT_P41 1
`define PPF_SLOT_P42 2
`define PPF_SLOT_P43 3

// level-change sampling rate
`define PPF_CLK_HZ 20000000
`define PPF_SAMPLE_HZ 64
`define PPF_SAMPLE_DIV (`PPF_CLK_HZ / `PPF_SAMPLE_HZ)

`endif

// ---- include/port_pin_pkg.sv ----
// types shared by the pin function control block
package port_pin_pkg;

  typedef struct packed {
    logic irq_en;
    logic func_sel;
    logic dir;
    logic drive_mode;
  } pin_ctrl_s;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_down;
  } pad_drive_s;

  typedef logic [7:0] reg_index_t;

endpackage

// ---- test/pad_board_model.sv ----
// board-side model of the four pads, their resistors and outside drivers
`timescale 1ns/10ps
`default_nettype none

module pad_board_model
(
  // device side
  input wire logic i_clk_sys,
  input wire logic [3:0] i_oe,
  input wire logic [3:0] i_out,
  input wire logic [3:0] i_pu,
  input wire logic [3:0] i_pd,
  // board side
  input wire logic [3:0] i_ext_en,
  input wire logic [3:0] i_ext_lvl,
  output logic [3:0] o_pad
);
  logic [3:0] float_r = 4'h0;

  // an unbiased undriven pad wanders, never a stale level
  always @(posedge i_clk_sys)
    float_r <= ~float_r;

  // device drive wins, then the board, then the resistors
  always_comb
    for (int i = 0; i < 4; i++)
      o_pad[i] = i_oe[i] ? i_out[i] : i_ext_en[i] ? i_ext_lvl[i] :
        i_pu[i] ? 1'b1 : i_pd[i] ? 1'b0 : float_r[i];
endmodule // pad_board_model

`default_nettype wire

// ---- test/port_pin_function_control_tb_top.sv ----
// self-checking bench for the pin function control block
`timescale 1ns/10ps
`include "port_pin_defs.svh"
`default_nettype none

module port_pin_function_control_tb_top;
  import port_pin_pkg::*;
  localparam int DIV = 16;
  typedef struct {int k; logic [31:0] v;} note_s;
  logic i_clk_sys = 1'b0;
  logic i_rstn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, pp = 1'b0, ecc = 1'b0;
  logic rdy = 1'b0, sck = 1'b0, rc = 1'b0;
  logic hready, hresp, sdi, sci, irq;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_obs;
  logic [3:0] pad, pout, poe, pu, pd, lvl, om, pdata = 4'h0;
  logic [3:0] ext = 4'h0, ext_en = 4'hF;
  logic [3:0] ctrl [4];
  reg_index_t idx [4] = '{`PPF_IDX_PIN33_CTRL, `PPF_IDX_PIN41_CTRL,
    `PPF_IDX_PIN42_CTRL, `PPF_IDX_PIN43_CTRL};
  int obs_irq, n_mismatch = 0, tests_run = 0, seed = 14902;
  note_s q[$];
  event look;

  always #25 i_clk_sys = ~i_clk_sys;

  port_pin_function_control #(.SAMPLE_DIV(DIV)) u_port_pin_function_control
  (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_pad_in(pad), .o_pad_out(pout), .o_pad_oe(poe),
    .o_pull_up_en(pu), .o_pull_down_en(pd), .i_port_data(pdata),
    .o_port_level(lvl), .i_external_clock_choice(ecc),
    .i_serial_data_ready(rdy), .i_serial_clock_out(sck),
    .i_rc_osc_clk(rc), .o_serial_data_in(sdi), .o_serial_clock_in(sci),
    .o_external_irq_zero(irq)
  );

  pad_board_model u_pad_board_model
  (
    .i_clk_sys(i_clk_sys), .i_oe(poe), .i_out(pout), .i_pu(pu),
    .i_pd(pd), .i_ext_en(ext_en), .i_ext_lvl(ext), .o_pad(pad)
  );

  // ==========================================
  // reporting and comparison
  task automatic report_and_stop;
    $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic bad(input string m);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic cmp_word(input logic [31:0] e, input logic [31:0] o);
    tests_run++;
    if (o !== e)
      bad($sformatf("read %h want %h", o, e));
  endtask

  task automatic cmp_pads(input logic [21:0] e, input logic [21:0] o);
    tests_run++;
    if (o !== e)
      bad($sformatf("pads %h want %h", o, e));
  endtask

  task automatic cmp_irq(input int e, input int o);
    tests_run++;
    if (o != e)
      bad($sformatf("%0d irq pulses, want %0d", o, e));
  endtask

  // the watcher takes the oldest note whenever a result is ready
  always @(look)
  begin
    note_s n;
    n = q.pop_front();
    if (n.k == 0)
      cmp_word(n.v, rd_obs);
    else if (n.k == 1)
      cmp_pads(n.v[21:0], {poe, pout & om, pu, pd, sdi, sci, lvl});
    else
      cmp_irq(int'(n.v), obs_irq);
  end

  // ==========================================
  // bus and pad tasks
  task automatic rdy_wait;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge i_clk_sys);
      if (hready === 1'b1)
        return;
    end
    bad("bus hang");
    report_and_stop;
  endtask

  task automatic xfer(input logic w, input reg_index_t a,
    input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, a, 2'h0};
    rdy_wait;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy_wait;
    rd_obs = hrdata;
  endtask

  task automatic rd(input reg_index_t a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    q.push_back('{0, e});
    ->look;
  endtask

  task automatic setall;
    for (int i = 0; i < 4; i++)
      xfer(1'b1, idx[i], {28'h0, ctrl[i]});
    xfer(1'b1, `PPF_IDX_PULL_POL, {31'h0, pp});
  endtask

  function automatic logic [21:0] want;
    logic [3:0] oe, o, u, dn, l, c;
    logic dir, src;
    for (int i = 0; i < 4; i++)
    begin
      c = ctrl[i];
      dir = c[2] ? (i == 0 ? 1'b0 : i == 2 ? ~ecc : 1'b1) : c[1];
      src = (!c[2] || i == 0) ? pdata[i] : i == 1 ? rdy : i == 2 ? sck : rc;
      oe[i] = dir & ~(c[0] & src);
      o[i] = dir & ~c[0] & src;
      u[i] = ~dir & ~c[0] & ~pp;
      dn[i] = ~dir & ~c[0] & pp;
      om[i] = dir | c[0];
      l[i] = oe[i] ? o[i] : ext_en[i] ? ext[i] : u[i];
    end
    return {oe, o, u, dn, ctrl[0][2] & l[0], ctrl[2][2] & ecc & l[2], l};
  endfunction

  // out is only judged where it is meant to be driven or held low
  task automatic chk_pads;
    repeat (6) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    q.push_back('{1, 32'(want())});
    ->look;
    @(posedge i_clk_sys);
  endtask

  task automatic irq_case(input logic [3:0] m, input logic [3:0] c,
    input int e);
    for (int i = 0; i < 4; i++)
      ctrl[i] = m[i] ? c : 4'h0;
    setall;
    repeat (40) @(posedge i_clk_sys);
    ext <= ext ^ m;
    obs_irq = 0;
    repeat (DIV + 6)
    begin
      @(negedge i_clk_sys);
      obs_irq += int'(irq === 1'b1);
    end
    q.push_back('{2, 32'(e)});
    ->look;
    @(posedge i_clk_sys);
  endtask

  initial
  begin
    #1000000;
    bad("run timeout");
    report_and_stop;
  end

  initial
  begin
    for (int i = 0; i < 4; i++)
      ctrl[i] = 4'h0;
    repeat (20) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    @(posedge i_clk_sys);
    chk_pads;
    $display("test done: reset state");
    for (int k = 0; k < 12; k++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        ctrl[i] = 4'($random(seed));
        if (k < 2)
          ctrl[i][2] = 1'b1;
      end
      pp = 1'($random(seed));
      pdata <= 4'($random(seed));
      ext <= 4'($random(seed));
      ecc <= (k < 2) ? k[0] : 1'($random(seed));
      rdy <= 1'($random(seed));
      sck <= 1'($random(seed));
      rc <= 1'($random(seed));
      setall;
      chk_pads;
    end
    $display("test done: random pin setups");
    for (int i = 0; i < 4; i++)
      rd(idx[i], 32'h0);
    rd(`PPF_IDX_PULL_POL, {31'h0, pp});
    rd(8'hFF, 32'h0);
    $display("test done: register reads");
    ext_en <= 4'h0;
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 0; i < 4; i++)
        ctrl[i] = 4'h0;
      pp = p[0];
      setall;
      chk_pads;
      rd(`PPF_IDX_STATUS, {28'h0, {4{~pp}}});
    end
    ext_en <= 4'hF;
    $display("test done: pull resistors");
    for (int i = 0; i < 4; i++)
      irq_case(4'(1 << i), 4'h8, 1);
    irq_case(4'h5, 4'h8, 1);
    irq_case(4'hF, 4'hA, 0);
    irq_case(4'hF, 4'h0, 0);
    $display("test done: level-change requests");
    report_and_stop;
  end
endmodule // port_pin_function_control_tb_top

`default_nettype wire
